// File: pkg/pcdb_defs.vh
/*
  Constants for the peripheral clock divider bank: register offsets,
  field positions, widths and reset values.
  Assumes inclusion by the design files of the bank only.
*/
`ifndef PCDB_DEFS_VH
`define PCDB_DEFS_VH

// register byte offsets
`define PCDB_OFS_FAST_REF 12'h080
`define PCDB_OFS_SLOW_REF 12'h084
`define PCDB_OFS_REF_SEL 12'h088
`define PCDB_OFS_CORE_DIV 12'h08c
`define PCDB_OFS_PERI_A 12'h090
`define PCDB_OFS_PERI_B 12'h094
`define PCDB_OFS_PERI_C 12'h098

// fractional divider fields
`define PCDB_NUM_MSB 23
`define PCDB_NUM_LSB 11
`define PCDB_DEN_MSB 10
`define PCDB_DEN_LSB 0
`define PCDB_NUM_W 13
`define PCDB_DEN_W 11
`define PCDB_FAST_NUM_RST 13'h1072
`define PCDB_FAST_DEN_RST 11'h4e3
`define PCDB_SLOW_NUM_RST 13'h07a1
`define PCDB_SLOW_DEN_RST 11'h090

// serial port select
`define PCDB_PORTS 4
`define PCDB_SEL_RST 4'h0

// core divisor
`define PCDB_CORE_MSB 5
`define PCDB_CORE_LSB 0
`define PCDB_CORE_RST 6'h01

// peripheral divider a
`define PCDB_RSVD_A_MSB 30
`define PCDB_RSVD_A_LSB 20
`define PCDB_RSVD_A_VAL 11'h021
`define PCDB_SDIO_MSB 19
`define PCDB_SDIO_LSB 16
`define PCDB_SDIO_RST 4'h1
`define PCDB_SYNC_W 5
`define PCDB_SYNC0_LSB 0
`define PCDB_SYNC1_LSB 5
`define PCDB_SYNC2_LSB 10
`define PCDB_SYNC_RST 15'h0842

// peripheral divider b
`define PCDB_QUAD_MSB 10
`define PCDB_QUAD_LSB 8
`define PCDB_FLASH_MSB 6
`define PCDB_FLASH_LSB 4
`define PCDB_B3_RST 3'h1

// peripheral divider c
`define PCDB_WDT_HI_MSB 6
`define PCDB_WDT_HI_LSB 4
`define PCDB_WDT_MID_BIT 28
`define PCDB_WDT_LO_MSB 25
`define PCDB_WDT_LO_LSB 24
`define PCDB_I2C_MSB 21
`define PCDB_I2C_LSB 20
`define PCDB_I2C_RST 2'h1
`define PCDB_TMR_HI_MSB 14
`define PCDB_TMR_HI_LSB 12
`define PCDB_TMR_LO_MSB 10
`define PCDB_TMR_LO_LSB 8
`define PCDB_SAMP_MSB 2
`define PCDB_SAMP_LSB 0
`define PCDB_SAMP_RST 3'h1
`define PCDB_WDT_CNT_W 64

`endif

// File: src/pcdb_frac_div.v
/*
  Fractional clock-enable divider: average tick rate is den/num of the
  reference, ticks spread by an accumulator.
  Assumes num_i and den_i are static levels from the register file.
*/
`timescale 1ns/1ps
`include "pcdb_defs.vh"
module pcdb_frac_div (
  // clock and control
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // ratio and tick
  input wire [`PCDB_NUM_W-1:0] num_i,
  input wire [`PCDB_DEN_W-1:0] den_i,
  output reg tick_o
);
  reg [`PCDB_NUM_W:0] acc_ff;
  reg [`PCDB_NUM_W-1:0] num_ff;
  reg [`PCDB_DEN_W-1:0] den_ff;
  wire [`PCDB_NUM_W:0] sum = acc_ff + {3'h0, den_ff};
  wire hit = (sum >= {1'b0, num_ff});
  wire [`PCDB_NUM_W:0] rem = sum - {1'b0, num_ff};

  // overflow spread evenly: a tick each time the sum passes num
  always @(posedge clk_i) begin
    if (rst_i) begin
      acc_ff <= 14'h0000;
      num_ff <= `PCDB_NUM_W'h0;
      den_ff <= `PCDB_DEN_W'h0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      tick_o <= hit;
      if (hit) begin
        // ratio swapped only after a tick, never mid-period
        num_ff <= num_i;
        den_ff <= den_i;
        // den above num saturates to a tick every cycle
        acc_ff <= (rem >= {1'b0, num_ff}) ? 14'h0000 : rem;
      end else begin
        acc_ff <= sum;
      end
    end
  end
endmodule

// File: src/pcdb_int_div.v
/*
  Integer clock-enable divider: one tick every div_i reference cycles.
  Assumes div_i is a static level from the register file; 0 means 1.
*/
`timescale 1ns/1ps
`include "pcdb_defs.vh"
module pcdb_int_div #(
  parameter W = 6
) (
  // clock and control
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // divisor and tick
  input wire [W-1:0] div_i,
  output reg tick_o
);
  reg [W-1:0] cnt_ff;
  reg [W-1:0] lim_ff;
  wire [W-1:0] eff = (div_i == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : div_i;
  wire wrap = (cnt_ff >= lim_ff);

  // new divisor only taken at a period end so no period is cut short
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= {{(W-1){1'b0}}, 1'b1};
      lim_ff <= {{(W-1){1'b0}}, 1'b1};
      tick_o <= 1'b0;
    end else if (ce_i) begin
      tick_o <= wrap;
      if (wrap) begin
        cnt_ff <= {{(W-1){1'b0}}, 1'b1};
        lim_ff <= eff;
      end else begin
        cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// File: src/pcdb_top.v
/*
  Peripheral clock divider bank: APB register file, two fractional
  serial-port references, per-port reference select and integer dividers
  that produce one-cycle clock-enable ticks for each consumer.
  Assumes an APB master on REF_CLK_I; clock gating cells downstream
  turn the ticks into clocks.
*/
`timescale 1ns/1ps
`include "pcdb_defs.vh"
module pcdb_top (
  // clock, reset, enable
  input wire REF_CLK_I,
  input wire RST_I,
  input wire CE_I,
  // apb slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg PREADY_O,
  output reg [31:0] PRDATA_O,
  output reg PSLVERR_O,
  // reference ticks
  output wire FAST_REF_TICK_O,
  output wire SLOW_REF_TICK_O,
  output reg [`PCDB_PORTS-1:0] SERIAL_PORT_TICK_O,
  // divided ticks
  output wire CORE_TICK_O,
  output wire SDIO_TICK_O,
  output wire [2:0] SYNC_PORT_TICK_O,
  output wire QUAD_PORT_TICK_O,
  output wire FLASH_TICK_O,
  output wire WDT_TICK_O,
  output wire I2C_TICK_O,
  output wire TIMER3_TICK_O,
  output wire SAMPLE_TICK_O
);
  // register fields
  reg [`PCDB_NUM_W-1:0] fast_num_ff;
  reg [`PCDB_DEN_W-1:0] fast_den_ff;
  reg [`PCDB_NUM_W-1:0] slow_num_ff;
  reg [`PCDB_DEN_W-1:0] slow_den_ff;
  reg [`PCDB_PORTS-1:0] serial_port_ref_choice_ff;
  reg [5:0] core_div_ff;
  reg [3:0] sdio_div_ff;
  reg [14:0] sync_port_divisor_ff;
  reg [2:0] quad_port_divisor_ff;
  reg [2:0] flash_div_ff;
  reg [2:0] wdt_hi_ff;
  reg wdt_mid_ff;
  reg [1:0] wdt_lo_ff;
  reg [1:0] i2c_div_ff;
  reg [2:0] timer3_divisor_upper_ff;
  reg [2:0] timer3_divisor_lower_ff;
  reg [2:0] sample_div_ff;
  // per-port select actually in use
  reg [`PCDB_PORTS-1:0] act_sel_ff;

  // apb decode
  wire access = PSEL_I & PENABLE_I;
  wire commit = access & PREADY_O;
  wire wr = commit & PWRITE_I;
  reg [31:0] rd_data;
  reg hit;

  always @* begin
    rd_data = 32'h0000_0000;
    hit = 1'b1;
    // reserved bits read as zero except the fixed field of divider a
    case (PADDR_I)
      `PCDB_OFS_FAST_REF: begin
        rd_data[`PCDB_NUM_MSB:`PCDB_NUM_LSB] = fast_num_ff;
        rd_data[`PCDB_DEN_MSB:`PCDB_DEN_LSB] = fast_den_ff;
      end
      `PCDB_OFS_SLOW_REF: begin
        rd_data[`PCDB_NUM_MSB:`PCDB_NUM_LSB] = slow_num_ff;
        rd_data[`PCDB_DEN_MSB:`PCDB_DEN_LSB] = slow_den_ff;
      end
      `PCDB_OFS_REF_SEL: begin
        rd_data[`PCDB_PORTS-1:0] = serial_port_ref_choice_ff;
      end
      `PCDB_OFS_CORE_DIV: begin
        rd_data[`PCDB_CORE_MSB:`PCDB_CORE_LSB] = core_div_ff;
      end
      `PCDB_OFS_PERI_A: begin
        rd_data[`PCDB_RSVD_A_MSB:`PCDB_RSVD_A_LSB] = `PCDB_RSVD_A_VAL;
        rd_data[`PCDB_SDIO_MSB:`PCDB_SDIO_LSB] = sdio_div_ff;
        rd_data[`PCDB_SYNC2_LSB+`PCDB_SYNC_W-1:`PCDB_SYNC0_LSB] = sync_port_divisor_ff;
      end
      `PCDB_OFS_PERI_B: begin
        rd_data[`PCDB_QUAD_MSB:`PCDB_QUAD_LSB] = quad_port_divisor_ff;
        rd_data[`PCDB_FLASH_MSB:`PCDB_FLASH_LSB] = flash_div_ff;
      end
      `PCDB_OFS_PERI_C: begin
        rd_data[`PCDB_WDT_MID_BIT] = wdt_mid_ff;
        rd_data[`PCDB_WDT_LO_MSB:`PCDB_WDT_LO_LSB] = wdt_lo_ff;
        rd_data[`PCDB_I2C_MSB:`PCDB_I2C_LSB] = i2c_div_ff;
        rd_data[`PCDB_TMR_HI_MSB:`PCDB_TMR_HI_LSB] = timer3_divisor_upper_ff;
        rd_data[`PCDB_TMR_LO_MSB:`PCDB_TMR_LO_LSB] = timer3_divisor_lower_ff;
        rd_data[`PCDB_WDT_HI_MSB:`PCDB_WDT_HI_LSB] = wdt_hi_ff;
        rd_data[`PCDB_SAMP_MSB:`PCDB_SAMP_LSB] = sample_div_ff;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // one wait state: pready is a flop so the bus answer is registered
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      PREADY_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else if (CE_I) begin
      PREADY_O <= access & ~PREADY_O;
      PRDATA_O <= (access & ~PREADY_O & ~PWRITE_I) ? rd_data : 32'h0000_0000;
      PSLVERR_O <= access & ~PREADY_O & ~hit;
    end
  end

  // register writes land on the edge that completes the transfer
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      fast_num_ff <= `PCDB_FAST_NUM_RST;
      fast_den_ff <= `PCDB_FAST_DEN_RST;
      slow_num_ff <= `PCDB_SLOW_NUM_RST;
      slow_den_ff <= `PCDB_SLOW_DEN_RST;
      serial_port_ref_choice_ff <= `PCDB_SEL_RST;
      core_div_ff <= `PCDB_CORE_RST;
      sdio_div_ff <= `PCDB_SDIO_RST;
      sync_port_divisor_ff <= `PCDB_SYNC_RST;
      quad_port_divisor_ff <= `PCDB_B3_RST;
      flash_div_ff <= `PCDB_B3_RST;
      wdt_hi_ff <= 3'h0;
      wdt_mid_ff <= 1'b0;
      wdt_lo_ff <= 2'h0;
      i2c_div_ff <= `PCDB_I2C_RST;
      timer3_divisor_upper_ff <= 3'h0;
      timer3_divisor_lower_ff <= 3'h0;
      sample_div_ff <= `PCDB_SAMP_RST;
    end else if (CE_I & wr) begin
      case (PADDR_I)
        `PCDB_OFS_FAST_REF: begin
          fast_num_ff <= PWDATA_I[`PCDB_NUM_MSB:`PCDB_NUM_LSB];
          fast_den_ff <= PWDATA_I[`PCDB_DEN_MSB:`PCDB_DEN_LSB];
        end
        `PCDB_OFS_SLOW_REF: begin
          slow_num_ff <= PWDATA_I[`PCDB_NUM_MSB:`PCDB_NUM_LSB];
          slow_den_ff <= PWDATA_I[`PCDB_DEN_MSB:`PCDB_DEN_LSB];
        end
        `PCDB_OFS_REF_SEL: begin
          serial_port_ref_choice_ff <= PWDATA_I[`PCDB_PORTS-1:0];
        end
        `PCDB_OFS_CORE_DIV: begin
          core_div_ff <= PWDATA_I[`PCDB_CORE_MSB:`PCDB_CORE_LSB];
        end
        `PCDB_OFS_PERI_A: begin
          // the fixed field 30:20 is not storage, so a bad write cannot move it
          sdio_div_ff <= PWDATA_I[`PCDB_SDIO_MSB:`PCDB_SDIO_LSB];
          sync_port_divisor_ff <= PWDATA_I[`PCDB_SYNC2_LSB+`PCDB_SYNC_W-1:`PCDB_SYNC0_LSB];
        end
        `PCDB_OFS_PERI_B: begin
          quad_port_divisor_ff <= PWDATA_I[`PCDB_QUAD_MSB:`PCDB_QUAD_LSB];
          flash_div_ff <= PWDATA_I[`PCDB_FLASH_MSB:`PCDB_FLASH_LSB];
        end
        `PCDB_OFS_PERI_C: begin
          wdt_hi_ff <= PWDATA_I[`PCDB_WDT_HI_MSB:`PCDB_WDT_HI_LSB];
          wdt_mid_ff <= PWDATA_I[`PCDB_WDT_MID_BIT];
          wdt_lo_ff <= PWDATA_I[`PCDB_WDT_LO_MSB:`PCDB_WDT_LO_LSB];
          i2c_div_ff <= PWDATA_I[`PCDB_I2C_MSB:`PCDB_I2C_LSB];
          timer3_divisor_upper_ff <= PWDATA_I[`PCDB_TMR_HI_MSB:`PCDB_TMR_HI_LSB];
          timer3_divisor_lower_ff <= PWDATA_I[`PCDB_TMR_LO_MSB:`PCDB_TMR_LO_LSB];
          sample_div_ff <= PWDATA_I[`PCDB_SAMP_MSB:`PCDB_SAMP_LSB];
        end
        default: begin
          fast_num_ff <= fast_num_ff;
        end
      endcase
    end
  end

  // fractional references
  pcdb_frac_div u_fast (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .num_i(fast_num_ff),
    .den_i(fast_den_ff),
    .tick_o(FAST_REF_TICK_O)
  );
  pcdb_frac_div u_slow (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .num_i(slow_num_ff),
    .den_i(slow_den_ff),
    .tick_o(SLOW_REF_TICK_O)
  );

  // per-port routing; a port swaps source only right after its current
  // source ticked, so the period in flight always completes
  wire [`PCDB_PORTS-1:0] cur_tick;
  genvar gi;
  generate
    for (gi = 0; gi < `PCDB_PORTS; gi = gi + 1) begin : g_port
      assign cur_tick[gi] = act_sel_ff[gi] ? FAST_REF_TICK_O : SLOW_REF_TICK_O;
    end
  endgenerate

  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      act_sel_ff <= `PCDB_SEL_RST;
      SERIAL_PORT_TICK_O <= `PCDB_SEL_RST;
    end else if (CE_I) begin
      SERIAL_PORT_TICK_O <= cur_tick;
      act_sel_ff <= (act_sel_ff & ~cur_tick) | (serial_port_ref_choice_ff & cur_tick);
    end
  end

  // divisor assembly
  wire [5:0] wdt_val = {wdt_hi_ff, wdt_mid_ff, wdt_lo_ff};
  // zero gives 1 << 0 = 1, otherwise two to the value
  wire [`PCDB_WDT_CNT_W-1:0] wdt_div = {{(`PCDB_WDT_CNT_W-1){1'b0}}, 1'b1} << wdt_val;
  wire [5:0] tmr3_div = {timer3_divisor_upper_ff, timer3_divisor_lower_ff};

  // integer dividers; zero is treated as one inside
  pcdb_int_div #(.W(6)) u_core (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .div_i(core_div_ff),
    .tick_o(CORE_TICK_O)
  );
  pcdb_int_div #(.W(4)) u_sdio (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .div_i(sdio_div_ff),
    .tick_o(SDIO_TICK_O)
  );
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      pcdb_int_div #(.W(`PCDB_SYNC_W)) u_sync (
        .clk_i(REF_CLK_I), .rst_i(RST_I), .ce_i(CE_I),
        .div_i(sync_port_divisor_ff[gi*`PCDB_SYNC_W +: `PCDB_SYNC_W]),
        .tick_o(SYNC_PORT_TICK_O[gi])
      );
    end
  endgenerate
  pcdb_int_div #(.W(3)) u_quad (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .div_i(quad_port_divisor_ff),
    .tick_o(QUAD_PORT_TICK_O)
  );
  pcdb_int_div #(.W(3)) u_flash (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .div_i(flash_div_ff),
    .tick_o(FLASH_TICK_O)
  );
  // a 64-bit counter is the price of the full 2^63 range
  pcdb_int_div #(.W(`PCDB_WDT_CNT_W)) u_wdt (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .div_i(wdt_div),
    .tick_o(WDT_TICK_O)
  );
  pcdb_int_div #(.W(2)) u_i2c (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .div_i(i2c_div_ff),
    .tick_o(I2C_TICK_O)
  );
  pcdb_int_div #(.W(6)) u_tmr3 (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .div_i(tmr3_div),
    .tick_o(TIMER3_TICK_O)
  );
  pcdb_int_div #(.W(3)) u_samp (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .div_i(sample_div_ff),
    .tick_o(SAMPLE_TICK_O)
  );
endmodule

// File: verif/pcdb_top_monitor.sv
/*
  assertion checker for the clock divider bank, bound to pcdb_top.
  assumes one clock domain with the enable held high while checked.
*/
`timescale 1ns/1ps
module pcdb_top_monitor (
  // clock and control
  input wire REF_CLK_I,
  input wire RST_I,
  input wire CE_I,
  // apb
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire PREADY_O,
  input wire [31:0] PRDATA_O,
  input wire PSLVERR_O,
  // ticks
  input wire FAST_REF_TICK_O,
  input wire SLOW_REF_TICK_O,
  input wire [3:0] SERIAL_PORT_TICK_O,
  input wire CORE_TICK_O
);
  default clocking @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I || !CE_I);
  // offsets 0x080 to 0x098, word aligned
  wire mapped = PADDR_I[11:5] == 7'h04 && PADDR_I[1:0] == 2'b00 && PADDR_I[4:2] != 3'h7;
  sequence setup_s;
    PSEL_I && !PENABLE_I;
  endsequence
  sequence access_s;
    PSEL_I && PENABLE_I && !PREADY_O ##1 PSEL_I && PENABLE_I && PREADY_O;
  endsequence
  one_wait_a: assert property (setup_s |=> access_s)
    else $error("apb answer not after one wait state");
  ready_cause_a: assert property (PREADY_O |-> PSEL_I && PENABLE_I && $past(PSEL_I && PENABLE_I))
    else $error("ready without access phase");
  ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  err_map_a: assert property (PREADY_O |-> PSLVERR_O == !mapped)
    else $error("error flag does not match address map");
  err_only_a: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error flag outside an answer");
  rdata_idle_a: assert property (!(PREADY_O && !PWRITE_I) || PSLVERR_O |-> PRDATA_O == 32'h0)
    else $error("read data not zero outside a read answer");
  reset_quiet_a: assert property (@(posedge REF_CLK_I) disable iff (!CE_I)
    RST_I |=> !PREADY_O && !CORE_TICK_O && SERIAL_PORT_TICK_O == 4'h0)
    else $error("outputs active during reset");
  port_route_a: assert property (SERIAL_PORT_TICK_O != 4'h0 |-> $past(FAST_REF_TICK_O || SLOW_REF_TICK_O))
    else $error("port tick without a reference tick");
  core_reset_a: assert property ($fell(RST_I) |-> ##[0:2] CORE_TICK_O [*4])
    else $error("core divisor not one after reset");
endmodule

bind pcdb_top pcdb_top_monitor i_pcdb_top_monitor (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .CE_I(CE_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PREADY_O(PREADY_O),
  .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .FAST_REF_TICK_O(FAST_REF_TICK_O),
  .SLOW_REF_TICK_O(SLOW_REF_TICK_O), .SERIAL_PORT_TICK_O(SERIAL_PORT_TICK_O), .CORE_TICK_O(CORE_TICK_O));

// File: verif/tb_pcdb_top.sv
/*
  bench for the clock divider bank: register access, tick periods,
  fractional rates and serial port routing.
  assumes the bank alone on a 100 MHz clock; the enable drops once near
  the end to check that every tick output freezes.
*/
`timescale 1ns/1ps
module tb_pcdb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg ce = 1'b1;
  reg psel = 1'b0;
  reg pen = 1'b0;
  reg pwr = 1'b0;
  reg [11:0] padr = 12'h000;
  reg [31:0] pwd = 32'h0;
  wire pready, pslverr, fast, slow, core, sdio, quad, flash, wdt, i2c, tmr, samp;
  wire [31:0] prd;
  wire [3:0] sp;
  wire [2:0] sync;
  wire [12:0] tk = {samp, tmr, i2c, wdt, flash, quad, sync, sdio, core, slow, fast};
  int error_cnt = 0;
  int samples_checked = 0;
  integer seed = 68325;
  reg [31:0] mdl [0:6];
  reg [31:0] rv;
  reg ev, pf, ps;
  int n, k, i, t, c;
  always #5 clk = ~clk;
  pcdb_top i_pcdb_top (.REF_CLK_I(clk), .RST_I(rst), .CE_I(ce), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PREADY_O(pready), .PRDATA_O(prd),
    .PSLVERR_O(pslverr), .FAST_REF_TICK_O(fast), .SLOW_REF_TICK_O(slow), .SERIAL_PORT_TICK_O(sp),
    .CORE_TICK_O(core), .SDIO_TICK_O(sdio), .SYNC_PORT_TICK_O(sync), .QUAD_PORT_TICK_O(quad),
    .FLASH_TICK_O(flash), .WDT_TICK_O(wdt), .I2C_TICK_O(i2c), .TIMER3_TICK_O(tmr), .SAMPLE_TICK_O(samp));
  task conclude;
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // writable bits per register; reserved bits read back as zero except the fixed field of register 4
  function automatic [31:0] wmask(input int r);
    case (r)
      0, 1: wmask = 32'h00ffffff;
      2: wmask = 32'h0000000f;
      3: wmask = 32'h0000003f;
      4: wmask = 32'h000f7fff;
      5: wmask = 32'h00000770;
      default: wmask = 32'h13307777;
    endcase
  endfunction
  function automatic int expdiv(input int t);
    reg [5:0] v;
    case (t)
      2: v = mdl[3][5:0];
      3: v = {2'b00, mdl[4][19:16]};
      4, 5, 6: v = {1'b0, mdl[4][5 * (t - 4) +: 5]};
      7: v = {3'b000, mdl[5][10:8]};
      8: v = {3'b000, mdl[5][6:4]};
      9: v = {mdl[6][6:4], mdl[6][28], mdl[6][25:24]};
      10: v = {4'h0, mdl[6][21:20]};
      11: v = {mdl[6][14:12], mdl[6][10:8]};
      default: v = {3'b000, mdl[6][2:0]};
    endcase
    if (v == 6'h00)
      expdiv = 1;
    else if (t == 9)
      expdiv = 1 << v;
    else
      expdiv = v;
  endfunction
  task automatic apb(input bit w, input [11:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung transfer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prd;
    ev = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input int r, input [31:0] d);
    // software keeps reserved bits zero and the fixed field at its reset value
    mdl[r] = d & wmask(r) | (r == 4 ? 32'h02100000 : 32'h0);
    apb(1'b1, 12'h080 + 12'(4 * r), mdl[r]);
  endtask
  task automatic rd(input int r);
    apb(1'b0, 12'h080 + 12'(4 * r), 32'h0);
    chk(rv, mdl[r]);
    chk({31'h0, ev}, 32'h0);
  endtask
  // cycles until the next tick of output t
  task automatic per(input int t, output int p);
    p = 0;
    do begin
      @(posedge clk);
      #1;
      p++;
    end while (tk[t] !== 1'b1 && p < 4096);
  endtask
  initial begin
    #900_000;
    error_cnt++;
    conclude;
  end
  initial begin
    mdl[0] = 32'h008394e3;
    mdl[1] = 32'h003d0890;
    mdl[2] = 32'h0;
    mdl[3] = 32'h1;
    mdl[4] = 32'h02110842;
    mdl[5] = 32'h00000110;
    mdl[6] = 32'h00100001;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 7; i++) rd(i);
    apb(1'b0, 12'h09c, 32'h0);
    chk(rv, 32'h0);
    chk({31'h0, ev}, 32'h1);
    apb(1'b1, 12'h07c, 32'hffffffff);
    chk({31'h0, ev}, 32'h1);
    // round 0 reset values, 1 all zero, 2 all ones, then random
    for (k = 0; k < 6; k++) begin
      for (i = 2; i < 6 && k > 0; i++) wr(i, k < 3 ? {32{k[1]}} : $random(seed));
      // watchdog exponent kept small so the run stays short
      if (k > 0) wr(6, ((k < 3 ? {32{k[1]}} : $random(seed)) & 32'hefffff8f) | (k == 3 ? 32'h10000000 : k == 4 ? 32'h10 : 32'h0));
      for (t = 2; t < 13; t++) begin
        per(t, n);
        per(t, n);
        per(t, n);
        chk(n, expdiv(t));
      end
    end
    for (i = 0; i < 7; i++) rd(i);
    wr(0, {8'h0, 13'd5, 11'd2});
    wr(1, {8'h0, 13'd3, 11'd1});
    per(0, n);
    per(0, n);
    c = 0;
    repeat (100) begin
      @(posedge clk);
      #1;
      c += tk[0];
    end
    chk(c, 40);
    per(1, n);
    per(1, n);
    per(1, n);
    chk(n, 3);
    wr(0, {8'h0, 13'd4, 11'd4});
    per(0, n);
    per(0, n);
    per(0, n);
    chk(n, 1);
    for (k = 0; k < 3; k++) begin
      wr(2, $random(seed));
      repeat (8) @(posedge clk);
      #1;
      pf = tk[0];
      ps = tk[1];
      repeat (30) begin
        @(posedge clk);
        #1;
        chk(sp, (mdl[2][3:0] & {4{pf}}) | (~mdl[2][3:0] & {4{ps}}));
        pf = tk[0];
        ps = tk[1];
      end
    end
    // enable low must freeze every tick and the routing state
    @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
    #1;
    rv = {15'h0, sp, tk};
    repeat (6) begin
      @(posedge clk);
      #1;
      chk({15'h0, sp, tk}, rv);
    end
    @(posedge clk);
    ce <= 1'b1;
    conclude;
  end
endmodule
